// File: ucs_uart_ctrl.sv
// Functional notes
// - line and modem interrupt enables, cleared at reset
// - status read reports the held source; highest pending is picked only when none is held
// - reported source holds until it is cleared
// - sources: errors, received byte, empty holding, deltas
// - line status read clears line interrupt
// - reading received byte clears receive interrupt
// - status read or holding write clears transmit
// - modem status read clears modem interrupt
// - codes 0110, 0100, 0010, 0000, none 0001
// - status bit0 low while pending, else high
// - word length 5 to 8 bits
// - stop bits one, one and half, two
// - parity enable adds and checks parity
// - even select chooses odd or even parity
// - force bit fixes parity to inverse select
// - break bit holds transmit line at space
// - divisor access bit maps divisor latches low
// - terminal ready and send request pins inverted
// - modem bit2 drives ring in loopback
// - bit3 enables interrupt pin, lowers general output
// - modem bit4 enables internal loopback
// - data ready shows received byte held
// - holding empty set on shift, cleared on load
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ucs_uart_ctrl
  import ucs_pkg::*;
(
  // clock and reset
  input logic ref_clk,
  input logic reset_n,
  // axi4-lite slave
  input logic [31:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [31:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // receive shifter strobe
  input logic rxByteValid,
  input logic [7:0] rxByte,
  input logic rxParityBit,
  input logic rxFramingError,
  input logic rxBreak,
  // transmit shifter
  input logic txShiftLoad,
  input logic txShifterIdle,
  output logic [7:0] txHoldData,
  output logic txHoldFull,
  output logic txParity,
  // modem status logic
  input logic [7:0] modemState,
  output logic modemStateRead,
  // line format towards the shifters
  output logic [3:0] wordBits,
  output logic [2:0] stopHalfBits,
  output logic parityEnable,
  output logic txBreak,
  output logic loopbackEnable,
  output logic [15:0] divisor,
  // pins
  output logic dtrN,
  output logic rtsN,
  output logic generalOutputN,
  output logic loopbackRingOutN,
  output logic intOut,
  output logic intOutEnN
);

  ucs_fmt_if fmtBus ();
  ucs_line_format u_format (.fmt(fmtBus.fmt));

  logic [7:0] ier_q, lcr_q, mcr_q, spr_q, thr_q, rhr_q;
  logic [15:0] div_q;
  logic [3:0] lineErr_q;
  logic dataReady_q, thrEmpty_q, txPend_q;
  logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
  logic awHeld_q, wHeld_q, awBad_q, wLane_q;
  logic [2:0] awIdx_q;
  logic [7:0] wData_q;
  logic [1:0] bResp_q, rResp_q;
  logic [31:0] rData_q;
  logic modemRead_q;
  logic [7:0] outPins_q;
  logic [3:0] wordBits_q;
  logic [2:0] stopHalf_q;
  logic txParity_q;
  ucs_src_t curSrc_q, curSrc_d, srcPick;
  logic srcHold, lineAct, rxAct, txAct, modemAct;
  logic [3:0] isrCode;
  logic [7:0] lsrView, readMux;
  logic wrEn, rdEn, arBad;
  logic [2:0] arIdx;
  logic dlab, rdRhr, rdIsr, rdLsr, rdMsr, wrThr, wrIer;

  assign fmtBus.lineFormat = lcr_q;
  assign fmtBus.txData = thr_q;
  assign fmtBus.rxData = rxByte;
  assign fmtBus.rxParityBit = rxParityBit;

  // bus decode; the low two indices move to the divisor latches when selected
  assign dlab = lcr_q[LCR_DLAB];
  assign arIdx = s_axi_araddr[IDX_MSB:IDX_LSB];
  assign arBad = |s_axi_araddr[31:IDX_MSB+1];
  assign rdEn = s_axi_arvalid & arReady_q & ~arBad;
  assign wrEn = awHeld_q & wHeld_q & ~bValid_q & ~awBad_q & wLane_q;
  assign rdRhr = rdEn & (arIdx == IDX_DATA) & ~dlab;
  assign rdIsr = rdEn & (arIdx == IDX_ISR);
  assign rdLsr = rdEn & (arIdx == IDX_LSR);
  assign rdMsr = rdEn & (arIdx == IDX_MSR);
  assign wrThr = wrEn & (awIdx_q == IDX_DATA) & ~dlab;
  assign wrIer = wrEn & (awIdx_q == IDX_IER) & ~dlab;

  assign lsrView = {1'b0, thrEmpty_q & txShifterIdle, thrEmpty_q, lineErr_q, dataReady_q};

  // interrupt sources
  assign lineAct = ier_q[IER_LINE] & (|lineErr_q);
  assign rxAct = ier_q[IER_RX] & dataReady_q;
  assign txAct = ier_q[IER_TX] & txPend_q;
  assign modemAct = ier_q[IER_MODEM] & (|modemState[3:0]);

  // a source once reported stays until it drops; only then is the next one picked
  always_comb begin
    case (curSrc_q)
      SRC_NONE: srcHold = 1'b0;
      SRC_LINE: srcHold = lineAct;
      SRC_RX: srcHold = rxAct;
      SRC_TX: srcHold = txAct;
      SRC_MODEM: srcHold = modemAct;
      default: srcHold = 1'b0;
    endcase
    if (lineAct) begin
      srcPick = SRC_LINE;
    end else if (rxAct) begin
      srcPick = SRC_RX;
    end else if (txAct) begin
      srcPick = SRC_TX;
    end else if (modemAct) begin
      srcPick = SRC_MODEM;
    end else begin
      srcPick = SRC_NONE;
    end
    curSrc_d = srcHold ? curSrc_q : srcPick;
  end

  always_comb begin
    case (curSrc_q)
      SRC_LINE: isrCode = ISR_LINE;
      SRC_RX: isrCode = ISR_RX;
      SRC_TX: isrCode = ISR_TX;
      SRC_MODEM: isrCode = ISR_MODEM;
      default: isrCode = ISR_NONE;
    endcase
  end

  always_comb begin
    case (arIdx)
      IDX_DATA: readMux = dlab ? div_q[7:0] : rhr_q;
      IDX_IER: readMux = dlab ? div_q[15:8] : ier_q;
      IDX_ISR: readMux = {4'h0, isrCode};
      IDX_LCR: readMux = lcr_q;
      IDX_MCR: readMux = mcr_q;
      IDX_LSR: readMux = lsrView;
      IDX_MSR: readMux = modemState;
      IDX_SPR: readMux = spr_q;
      default: readMux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      curSrc_q <= SRC_NONE;
    end else begin
      curSrc_q <= curSrc_d;
    end
  end

  // write channels are taken in either order and answered once both are held
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awIdx_q <= 3'h0;
      awBad_q <= 1'b0;
      wData_q <= 8'h00;
      wLane_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awReady_q) begin
        awReady_q <= 1'b0;
        awHeld_q <= 1'b1;
        awIdx_q <= s_axi_awaddr[IDX_MSB:IDX_LSB];
        awBad_q <= |s_axi_awaddr[31:IDX_MSB+1];
      end
      if (s_axi_wvalid && wReady_q) begin
        wReady_q <= 1'b0;
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end
      if (awHeld_q && wHeld_q && !bValid_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= awBad_q ? RESP_SLVERR : RESP_OKAY;
      end
      if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
        awReady_q <= 1'b1;
        wReady_q <= 1'b1;
      end
    end
  end

  // read data is latched at the address edge, so side effects happen exactly once
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= RESP_OKAY;
      modemRead_q <= 1'b0;
    end else begin
      modemRead_q <= rdMsr;
      if (s_axi_arvalid && arReady_q) begin
        arReady_q <= 1'b0;
        rValid_q <= 1'b1;
        rData_q <= arBad ? 32'h0000_0000 : {24'h00_0000, readMux};
        rResp_q <= arBad ? RESP_SLVERR : RESP_OKAY;
      end
      if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
        arReady_q <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ier_q <= IER_RST;
      lcr_q <= LCR_RST;
      mcr_q <= MCR_RST;
      spr_q <= SPR_RST;
      div_q <= DIV_RST;
      thr_q <= 8'h00;
    end else if (wrEn) begin
      case (awIdx_q)
        IDX_DATA: begin
          if (dlab) begin
            div_q[7:0] <= wData_q;
          end else begin
            thr_q <= wData_q;
          end
        end
        IDX_IER: begin
          if (dlab) begin
            div_q[15:8] <= wData_q;
          end else begin
            ier_q <= wData_q & IER_MASK;
          end
        end
        IDX_LCR: lcr_q <= wData_q;
        IDX_MCR: mcr_q <= wData_q & MCR_MASK;
        IDX_SPR: spr_q <= wData_q;
        default: ier_q <= ier_q;
      endcase
    end
  end

  // receive holding; an arrival while full keeps the old byte and flags overrun
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rhr_q <= 8'h00;
      dataReady_q <= 1'b0;
      lineErr_q <= 4'h0;
    end else begin
      if (rxByteValid && (!dataReady_q || rdRhr)) begin
        rhr_q <= rxByte;
      end
      if (rxByteValid) begin
        dataReady_q <= 1'b1;
      end else if (rdRhr) begin
        dataReady_q <= 1'b0;
      end
      if (rxByteValid) begin
        lineErr_q <= (rdLsr ? 4'h0 : lineErr_q) |
                     {rxBreak, rxFramingError, fmtBus.rxParityError, dataReady_q & ~rdRhr};
      end else if (rdLsr) begin
        lineErr_q <= 4'h0;
      end
    end
  end

  // transmit holding empty and its interrupt
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      thrEmpty_q <= 1'b1;
      txPend_q <= 1'b0;
    end else begin
      if (wrThr) begin
        thrEmpty_q <= 1'b0;
      end else if (txShiftLoad) begin
        thrEmpty_q <= 1'b1;
      end
      // enabling while already empty raises the interrupt as well
      if ((txShiftLoad && !thrEmpty_q && !wrThr) ||
          (wrIer && wData_q[IER_TX] && !ier_q[IER_TX] && thrEmpty_q)) begin
        txPend_q <= 1'b1;
      end else if (wrThr || (rdIsr && curSrc_q == SRC_TX)) begin
        txPend_q <= 1'b0;
      end
    end
  end

  // pins and format outputs, registered one cycle behind the control bits
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      outPins_q <= 8'h1f;
      wordBits_q <= WORD_MIN;
      stopHalf_q <= STOP_ONE;
      txParity_q <= 1'b0;
    end else begin
      outPins_q[0] <= ~mcr_q[MCR_DTR];
      outPins_q[1] <= ~mcr_q[MCR_RTS];
      outPins_q[2] <= ~mcr_q[MCR_INTEN];
      outPins_q[3] <= ~mcr_q[MCR_RING];
      outPins_q[4] <= ~mcr_q[MCR_INTEN];
      outPins_q[5] <= curSrc_q != SRC_NONE;
      outPins_q[6] <= lcr_q[LCR_BREAK];
      outPins_q[7] <= mcr_q[MCR_LOOP];
      wordBits_q <= fmtBus.dataBits;
      stopHalf_q <= fmtBus.stopHalfBits;
      txParity_q <= fmtBus.txParity;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign txHoldData = thr_q;
  assign txHoldFull = ~thrEmpty_q;
  assign txParity = txParity_q;
  assign modemStateRead = modemRead_q;
  assign wordBits = wordBits_q;
  assign stopHalfBits = stopHalf_q;
  assign parityEnable = lcr_q[LCR_PEN];
  assign txBreak = outPins_q[6];
  assign loopbackEnable = outPins_q[7];
  assign divisor = div_q;
  assign dtrN = outPins_q[0];
  assign rtsN = outPins_q[1];
  assign generalOutputN = outPins_q[2];
  assign loopbackRingOutN = outPins_q[3];
  assign intOutEnN = outPins_q[4];
  assign intOut = outPins_q[5];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_ISR_NONE: assert property ((rdIsr && curSrc_q == SRC_NONE) |=> s_axi_rdata[3:0] == 4'h1)
    else $error("idle status read did not return 0001");
  AST_PRIO_LINE: assert property ((curSrc_q == SRC_NONE && lineAct) |=> curSrc_q == SRC_LINE ##1 intOut)
    else $error("line status not chosen first");
  AST_HOLD_RX: assert property ((curSrc_q == SRC_RX && rxAct) |=> curSrc_q == SRC_RX)
    else $error("reported source changed while pending");
  AST_ISR_CODE: assert property ((rdIsr && curSrc_q == SRC_RX) |=> s_axi_rdata[7:0] == 8'h04)
    else $error("wrong receive code");
  AST_RX_CLEAR: assert property ((rdRhr && !rxByteValid) |=> !dataReady_q)
    else $error("data ready stuck after read");
  AST_LSR_CLEAR: assert property ((rdLsr && !rxByteValid) |=> lineErr_q == 4'h0)
    else $error("line errors stuck after read");
  AST_TX_CLEAR: assert property ((wrThr && !txShiftLoad) |=> !txPend_q && !thrEmpty_q)
    else $error("transmit interrupt not cleared by load");
  AST_THR_EMPTY: assert property ((txShiftLoad && !wrThr) |=> thrEmpty_q)
    else $error("holding empty not set on shift");
  AST_DR_SET: assert property (rxByteValid |=> dataReady_q)
    else $error("data ready not set");
  AST_DTR_PIN: assert property ((wrEn && awIdx_q == IDX_MCR && wData_q[MCR_DTR]) |=> ##1 !dtrN)
    else $error("terminal ready pin not low");
  AST_INT_OFF: assert property (!mcr_q[MCR_INTEN] |=> intOutEnN && generalOutputN)
    else $error("interrupt pin driven while disabled");
  AST_BREAK: assert property (lcr_q[LCR_BREAK] |=> txBreak)
    else $error("break not held");
  AST_RSVD: assert property (ier_q[7:4] == 4'h0 && mcr_q[7:5] == 3'h0)
    else $error("reserved bits set");
  AST_STOP: assert property ((lcr_q[LCR_STOP] && lcr_q[1:0] == 2'h0) |=> stopHalfBits == STOP_ONE_HALF)
    else $error("wrong stop length");

  COV_LINE: cover property (curSrc_q == SRC_LINE ##1 rdLsr);
  COV_RX_HOLD: cover property (curSrc_q == SRC_RX && lineAct);
  COV_TX_ISR: cover property (rdIsr && curSrc_q == SRC_TX);

endmodule

// File: ucs_pkg.sv
package ucs_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER = 3'h1;
  localparam logic [2:0] IDX_ISR = 3'h2;
  localparam logic [2:0] IDX_LCR = 3'h3;
  localparam logic [2:0] IDX_MCR = 3'h4;
  localparam logic [2:0] IDX_LSR = 3'h5;
  localparam logic [2:0] IDX_MSR = 3'h6;
  localparam logic [2:0] IDX_SPR = 3'h7;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // interrupt enable fields
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam logic [7:0] IER_MASK = 8'h0f;

  // line format fields
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EVEN = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BREAK = 6;
  localparam int LCR_DLAB = 7;

  // modem output fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_RING = 2;
  localparam int MCR_INTEN = 3;
  localparam int MCR_LOOP = 4;
  localparam logic [7:0] MCR_MASK = 8'h1f;

  // reset values
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] SPR_RST = 8'hff;
  localparam logic [15:0] DIV_RST = 16'h0000;

  // interrupt status codes
  localparam logic [3:0] ISR_LINE = 4'h6;
  localparam logic [3:0] ISR_RX = 4'h4;
  localparam logic [3:0] ISR_TX = 4'h2;
  localparam logic [3:0] ISR_MODEM = 4'h0;
  localparam logic [3:0] ISR_NONE = 4'h1;

  // stop length in half bit times
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;
  localparam logic [3:0] WORD_MIN = 4'h5;

  typedef enum logic [4:0] {
    SRC_NONE  = 5'b00001,
    SRC_LINE  = 5'b00010,
    SRC_RX    = 5'b00100,
    SRC_TX    = 5'b01000,
    SRC_MODEM = 5'b10000
  } ucs_src_t;

endpackage

// File: ucs_fmt_if.sv
`timescale 1ns/1ps
interface ucs_fmt_if;
  logic [7:0] lineFormat;
  logic [7:0] txData;
  logic [7:0] rxData;
  logic rxParityBit;
  logic [3:0] dataBits;
  logic [2:0] stopHalfBits;
  logic txParity;
  logic rxParityError;
  modport ctrl (output lineFormat, output txData, output rxData, output rxParityBit,
                input dataBits, input stopHalfBits, input txParity, input rxParityError);
  modport fmt (input lineFormat, input txData, input rxData, input rxParityBit,
               output dataBits, output stopHalfBits, output txParity, output rxParityError);
endinterface

// File: ucs_line_format.sv
`timescale 1ns/1ps
module ucs_line_format
  import ucs_pkg::*;
(
  // format settings and characters
  ucs_fmt_if.fmt fmt
);

  // parity over the bits that the word length keeps; upper bits are masked off
  function automatic logic parity_bit(input logic [7:0] line_format_control, input logic [7:0] data);
    logic [7:0] mask;
    mask = 8'hff >> (2'h3 - line_format_control[1:0]);
    if (line_format_control[LCR_STICK]) begin
      parity_bit = ~line_format_control[LCR_EVEN];
    end else begin
      parity_bit = line_format_control[LCR_EVEN] ? ^(data & mask) : ~^(data & mask);
    end
  endfunction

  always_comb begin
    fmt.dataBits = WORD_MIN + {2'h0, fmt.lineFormat[1:0]};
    if (!fmt.lineFormat[LCR_STOP]) begin
      fmt.stopHalfBits = STOP_ONE;
    end else if (fmt.lineFormat[1:0] == 2'h0) begin
      fmt.stopHalfBits = STOP_ONE_HALF;
    end else begin
      fmt.stopHalfBits = STOP_TWO;
    end
  end

  // receive check uses the same format as transmit
  always_comb begin
    fmt.txParity = fmt.lineFormat[LCR_PEN] & parity_bit(fmt.lineFormat, fmt.txData);
    fmt.rxParityError = fmt.lineFormat[LCR_PEN] &
                        (fmt.rxParityBit != parity_bit(fmt.lineFormat, fmt.rxData));
  end

endmodule

// File: ucs_far_model.sv
`timescale 1ns/1ps
module ucs_far_model #(
  parameter int SHIFT_CYCLES = 40
) (
  // clock and reset
  input logic ref_clk,
  input logic reset_n,
  // bench commands
  input logic sendByte,
  input logic [7:0] sendData,
  input logic sendFrameErr,
  input logic sendParity,
  input logic [3:0] deltaSet,
  // receive shifter
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxParityBit,
  output logic rxFramingError,
  output logic rxBreak,
  // transmit shifter
  input logic [7:0] txHoldData,
  input logic txHoldFull,
  output logic txShiftLoad,
  output logic txShifterIdle,
  output logic [7:0] shiftedByte,
  // modem status logic
  input logic modemStateRead,
  output logic [7:0] modemState
);
  int holdAge;
  logic [3:0] deltas;

  // unqualified lines toggle so a stale value never passes for data
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rxByteValid <= 1'b0;
      rxByte <= 8'h00;
      rxParityBit <= 1'b0;
      rxFramingError <= 1'b0;
      rxBreak <= 1'b0;
    end else begin
      rxByteValid <= sendByte;
      rxByte <= sendByte ? sendData : ~rxByte;
      rxParityBit <= sendByte ? sendParity : ~rxParityBit;
      rxFramingError <= sendByte ? sendFrameErr : ~rxFramingError;
      rxBreak <= sendByte ? 1'b0 : ~rxBreak;
    end
  end

  // slow shifter: the host gets time to see the holding byte waiting
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      holdAge <= 0;
      txShiftLoad <= 1'b0;
      shiftedByte <= 8'h00;
    end else begin
      txShiftLoad <= 1'b0;
      holdAge <= txHoldFull ? holdAge + 1 : 0;
      if (txHoldFull && holdAge == SHIFT_CYCLES) begin
        txShiftLoad <= 1'b1;
        shiftedByte <= txHoldData;
        holdAge <= 0;
      end
    end
  end
  assign txShifterIdle = ~txShiftLoad;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      deltas <= 4'h0;
    end else begin
      deltas <= (modemStateRead ? 4'h0 : deltas) | deltaSet;
    end
  end
  // upper status lines parked inactive
  assign modemState = {4'h0, deltas};
endmodule

// File: ucs_uart_ctrl_tb.sv
`timescale 1ns/1ps
module ucs_uart_ctrl_tb;
  import ucs_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData, rd;
  logic [3:0] wStrb = 4'hf;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic sendByte = 1'b0, sendFrameErr = 1'b0, sendParity = 1'b0;
  logic [7:0] sendData = 8'h00;
  logic [3:0] deltaSet = 4'h0;
  logic rxByteValid, rxParityBit, rxFramingError, rxBreak, txShiftLoad, txShifterIdle, txHoldFull, txParity;
  logic [7:0] rxByte, txHoldData, shiftedByte, modemState;
  logic modemStateRead, parityEnable, txBreak, loopbackEnable, dtrN, rtsN, generalOutputN, loopbackRingOutN;
  logic intOut, intOutEnN;
  logic [3:0] wordBits;
  logic [2:0] stopHalfBits;
  logic [15:0] divisor;
  logic [7:0] parLcr [5] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b};
  logic parExp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int errTotal = 0;
  int numChecks = 0;
  int i;

  always #10 ref_clk = ~ref_clk;

  ucs_uart_ctrl ucs_uart_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxParityBit(rxParityBit),
    .rxFramingError(rxFramingError), .rxBreak(rxBreak), .txShiftLoad(txShiftLoad),
    .txShifterIdle(txShifterIdle), .txHoldData(txHoldData), .txHoldFull(txHoldFull), .txParity(txParity),
    .modemState(modemState), .modemStateRead(modemStateRead), .wordBits(wordBits),
    .stopHalfBits(stopHalfBits), .parityEnable(parityEnable), .txBreak(txBreak),
    .loopbackEnable(loopbackEnable), .divisor(divisor), .dtrN(dtrN), .rtsN(rtsN),
    .generalOutputN(generalOutputN), .loopbackRingOutN(loopbackRingOutN), .intOut(intOut),
    .intOutEnN(intOutEnN));

  ucs_far_model #(.SHIFT_CYCLES(40)) ucs_far_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .sendByte(sendByte), .sendData(sendData), .sendFrameErr(sendFrameErr), .sendParity(sendParity),
    .deltaSet(deltaSet), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxParityBit(rxParityBit),
    .rxFramingError(rxFramingError), .rxBreak(rxBreak), .txHoldData(txHoldData), .txHoldFull(txHoldFull),
    .txShiftLoad(txShiftLoad), .txShifterIdle(txShifterIdle), .shiftedByte(shiftedByte),
    .modemStateRead(modemStateRead), .modemState(modemState));

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timedOut();
    errTotal++;
    $display("CHECK FAILED wait expected answer seen none");
    tallyAndFinish();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] regAddr(input logic [2:0] idx);
    return {27'h0, idx, 2'h0};
  endfunction

  // valid and payload are held until the edge that samples ready
  task automatic busWrite(input logic [31:0] addr, input logic [7:0] data, input logic [1:0] expResp);
    int n;
    @(posedge ref_clk);
    awAddr <= addr;
    wData <= {24'h0, data};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid && bReady) begin
        bReady <= 1'b0;
        check("bresp", {30'h0, bResp}, {30'h0, expResp});
        return;
      end
    end
    timedOut();
  endtask

  task automatic busRead(input logic [31:0] addr, input logic [1:0] expResp, output logic [31:0] data);
    int n;
    @(posedge ref_clk);
    arAddr <= addr;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid && rReady) begin
        rReady <= 1'b0;
        data = rData;
        check("rresp", {30'h0, rResp}, {30'h0, expResp});
        return;
      end
    end
    timedOut();
  endtask

  task automatic rdChk(input string name, input logic [2:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    busRead(regAddr(idx), RESP_OKAY, v);
    check(name, v, {24'h0, exp});
  endtask

  // pins follow a write after two edges, so settle before looking
  task automatic wr(input logic [2:0] idx, input logic [7:0] data);
    busWrite(regAddr(idx), data, RESP_OKAY);
    tick(3);
  endtask

  task automatic sendRx(input logic [7:0] data, input logic frameErr, input logic parity);
    @(posedge ref_clk);
    sendByte <= 1'b1;
    sendData <= data;
    sendFrameErr <= frameErr;
    sendParity <= parity;
    @(posedge ref_clk);
    sendByte <= 1'b0;
    tick(4);
  endtask

  task automatic waitShift();
    int n;
    for (n = 0; n < 200 && txHoldFull !== 1'b0; n++) @(posedge ref_clk);
    if (n == 200) timedOut();
    tick(3);
  endtask

  initial begin
    tick(3);
    reset_n <= 1'b1;
    rdChk("ier", IDX_IER, 8'h00);
    rdChk("isr", IDX_ISR, {4'h0, ISR_NONE});
    rdChk("lcr", IDX_LCR, 8'h00);
    rdChk("lsr", IDX_LSR, 8'h60);
    check("pins", {26'h0, dtrN, rtsN, generalOutputN, intOutEnN, loopbackRingOutN, loopbackEnable}, 32'h3e);
    wr(IDX_IER, 8'hf0);
    rdChk("ier rsvd", IDX_IER, 8'h00);
    wr(IDX_MCR, 8'hff);
    rdChk("mcr rsvd", IDX_MCR, 8'h1f);
    check("pins on", {26'h0, dtrN, rtsN, generalOutputN, intOutEnN, loopbackRingOutN, loopbackEnable}, 32'h01);
    wr(IDX_ISR, 8'hfe);
    rdChk("isr ro", IDX_ISR, {4'h0, ISR_NONE});
    for (i = 0; i < 8; i++) begin
      wr(IDX_LCR, {5'h0, i[2:0]});
      check("word", {28'h0, wordBits}, 32'h5 + {30'h0, i[1:0]});
      check("stop", {29'h0, stopHalfBits}, {29'h0, !i[2] ? STOP_ONE : (i[1:0] == 2'h0 ? STOP_ONE_HALF : STOP_TWO)});
    end
    foreach (parLcr[k]) begin
      wr(IDX_LCR, parLcr[k]);
      wr(IDX_DATA, 8'h03);
      check("parity", {31'h0, txParity}, {31'h0, parExp[k]});
      check("par en", {31'h0, parityEnable}, {31'h0, parLcr[k][3]});
      waitShift();
    end
    wr(IDX_LCR, 8'h43);
    check("break", {31'h0, txBreak}, 32'h1);
    wr(IDX_LCR, 8'h83);
    wr(IDX_DATA, 8'h34);
    wr(IDX_IER, 8'h12);
    check("divisor", {16'h0, divisor}, 32'h1234);
    check("break off", {31'h0, txBreak}, 32'h0);
    wr(IDX_LCR, 8'h03);
    rdChk("ier map", IDX_IER, 8'h00);
    check("no load", {31'h0, txHoldFull}, 32'h0);
    busWrite(32'h20, 8'h55, RESP_SLVERR);
    busRead(32'h20, RESP_SLVERR, rd);
    check("unmapped", rd, 32'h0);
    // interrupt priority and clearing
    wr(IDX_MCR, 8'h08);
    wr(IDX_IER, 8'h0f);
    check("int pin", {30'h0, intOut, intOutEnN}, 32'h2);
    rdChk("tx en", IDX_ISR, {4'h0, ISR_TX});
    rdChk("tx rd clr", IDX_ISR, {4'h0, ISR_NONE});
    wr(IDX_DATA, 8'ha5);
    busRead(regAddr(IDX_LSR), RESP_OKAY, rd);
    check("thr full", {31'h0, rd[5]}, 32'h0);
    waitShift();
    check("shifted", {24'h0, shiftedByte}, 32'ha5);
    wr(IDX_DATA, 8'h5a);
    rdChk("tx wr clr", IDX_ISR, {4'h0, ISR_NONE});
    waitShift();
    rdChk("tx empty", IDX_ISR, {4'h0, ISR_TX});
    sendRx(8'h3c, 1'b0, 1'b1);
    rdChk("rx", IDX_ISR, {4'h0, ISR_RX});
    rdChk("dr", IDX_LSR, 8'h61);
    rdChk("rhr", IDX_DATA, 8'h3c);
    rdChk("rx clr", IDX_ISR, {4'h0, ISR_NONE});
    sendRx(8'h11, 1'b1, 1'b0);
    rdChk("line", IDX_ISR, {4'h0, ISR_LINE});
    rdChk("frame", IDX_LSR, 8'h69);
    rdChk("rx next", IDX_ISR, {4'h0, ISR_RX});
    rdChk("rhr", IDX_DATA, 8'h11);
    wr(IDX_LCR, 8'h0b);
    sendRx(8'h01, 1'b0, 1'b1);
    rdChk("par err", IDX_LSR, 8'h65);
    rdChk("rhr", IDX_DATA, 8'h01);
    wr(IDX_LCR, 8'h03);
    @(posedge ref_clk);
    deltaSet <= 4'h4;
    @(posedge ref_clk);
    deltaSet <= 4'h0;
    tick(3);
    rdChk("modem", IDX_ISR, {4'h0, ISR_MODEM});
    sendRx(8'h77, 1'b0, 1'b0);
    rdChk("held", IDX_ISR, {4'h0, ISR_MODEM});
    rdChk("msr", IDX_MSR, 8'h04);
    tick(4);
    rdChk("rx after", IDX_ISR, {4'h0, ISR_RX});
    rdChk("rhr", IDX_DATA, 8'h77);
    wr(IDX_IER, 8'h03);
    sendRx(8'h22, 1'b1, 1'b0);
    rdChk("line off", IDX_ISR, {4'h0, ISR_RX});
    rdChk("rhr", IDX_DATA, 8'h22);
    tick(3);
    check("int idle", {31'h0, intOut}, 32'h0);
    tallyAndFinish();
  end
endmodule
